// file: bto_defines.svh
// Constants for the bridge transaction ordering block
`ifndef BTO_DEFINES_SVH
`define BTO_DEFINES_SVH

// Queue geometry per direction
`define BTO_DIRS        2
`define BTO_DEPTH       4
`define BTO_IDX_W       2
`define BTO_CNT_W       3

// Issue buffer geometry
`define BTO_SKID_DEPTH  2
`define BTO_SKID_CNT_W  2

// Field widths
`define BTO_DATA_W      32
`define BTO_ADDR_W      32
`define BTO_CMD_W       4
`define BTO_STAMP_W     8

// Bus command codes that are writes
`define BTO_CMD_IO_WR   4'h3
`define BTO_CMD_MEM_WR  4'h7
`define BTO_CMD_CFG_WR  4'hB
`define BTO_CMD_MWI     4'hF

`endif

// file: bto_pkg.sv
// Types shared by the bridge transaction ordering block
package bto_pkg;
`include "bto_defines.svh"

	// Transaction classes held in the ordering queues
	typedef enum logic [2:0] {
		cls_posted_write,
		cls_delayed_read_request,
		cls_delayed_write_request,
		cls_delayed_read_completion,
		cls_delayed_write_completion
	} bto_cls_e;

	// Completion status returned by the target
	typedef enum logic [1:0] {
		sts_normal,
		sts_master_abort,
		sts_target_abort,
		sts_parity_error
	} bto_sts_e;

	typedef logic [`BTO_IDX_W-1:0]   bto_idx_t;
	typedef logic [`BTO_CNT_W-1:0]   bto_cnt_t;
	typedef logic [`BTO_STAMP_W-1:0] bto_stamp_t;
	typedef logic [`BTO_DATA_W-1:0]  bto_word_t;
	typedef logic [`BTO_ADDR_W-1:0]  bto_addr_t;
	typedef logic [`BTO_CMD_W-1:0]   bto_cmd_t;

	// Transaction accepted on the originating bus
	typedef struct packed {
		bto_cmd_t  cmd;
		bto_addr_t addr;
		bto_word_t data;
	} bto_txn_s;

	// Queue entry, also the word handed to the far bus
	typedef struct packed {
		bto_cls_e   cls;
		bto_cmd_t   cmd;
		bto_addr_t  addr;
		bto_word_t  data;
		bto_sts_e   sts;
		bto_stamp_t stamp;
		logic       tried;
	} bto_ent_s;

	// Outcome of one attempt on the far bus
	typedef struct packed {
		logic      retry;
		bto_sts_e  sts;
		bto_word_t data;
	} bto_res_s;

	// State of one direction's ordering queue
	typedef struct packed {
		bto_ent_s [`BTO_DEPTH-1:0] ent;
		bto_cnt_t                  cnt;
		logic                      inflight;
		bto_idx_t                  infl_idx;
		logic                      pref_delayed;
		bto_stamp_t                stamp;
		logic                      acc_ready;
		logic                      pw_pending;
		bto_cnt_t                  level;
	} bto_dq_s;

	typedef struct packed {
		bto_dq_s [`BTO_DIRS-1:0] q;
	} bto_top_s;

	typedef struct packed {
		bto_ent_s [`BTO_SKID_DEPTH-1:0] ent;
		logic [`BTO_SKID_CNT_W-1:0]     cnt;
		logic                           vld;
	} bto_skid_s;

endpackage

// file: bto_skid.sv
// Two-entry issue buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "bto_defines.svh"

module bto_skid
	import bto_pkg::*;
(
	input  logic     mclk,
	input  logic     reset,
	input  logic     in_valid,
	input  bto_ent_s in_ent,
	output logic     in_ready,
	output logic     out_valid,
	output bto_ent_s out_ent,
	input  logic     out_ready
);

	bto_skid_s st_reg;
	bto_skid_s st_next;

	// Room is judged on the stored count, so a full buffer stalls the source
	assign in_ready  = (st_reg.cnt != `BTO_SKID_CNT_W'(`BTO_SKID_DEPTH));
	assign out_valid = st_reg.vld;
	assign out_ent   = st_reg.ent[0];

	// Pop from the head first, then append behind what remains
	always_comb begin
		st_next = st_reg;
		if (st_reg.vld && out_ready) begin
			st_next.ent[0] = st_reg.ent[1];
			st_next.ent[1] = '0;
			st_next.cnt    = st_reg.cnt - 1'b1;
		end
		if (in_valid && in_ready) begin
			st_next.ent[st_next.cnt[0]] = in_ent;
			st_next.cnt                 = st_next.cnt + 1'b1;
		end
		st_next.vld = (st_next.cnt != '0);
	end

	// State register
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule

// file: bto_pick.sv
// Ordering decision: which queue entry may be attempted next
`timescale 1ns/100ps
`include "bto_defines.svh"

module bto_pick
	import bto_pkg::*;
(
	input  bto_ent_s [`BTO_DEPTH-1:0] ent,
	input  bto_cnt_t                  cnt,
	input  logic                      room_other,
	input  logic                      pref_delayed,
	output logic                      ok,
	output bto_idx_t                  idx
);

	logic     pw_ok;
	logic     cp_ok;
	logic     rq_ok;
	logic     seen_pw;
	bto_idx_t pw_idx;
	bto_idx_t cp_idx;
	bto_idx_t rq_idx;

	// Walk from oldest to youngest; anything behind a posted write waits
	always_comb begin
		pw_ok   = 1'b0;
		cp_ok   = 1'b0;
		rq_ok   = 1'b0;
		seen_pw = 1'b0;
		pw_idx  = '0;
		cp_idx  = '0;
		rq_idx  = '0;
		ok      = 1'b0;
		idx     = '0;
		for (int i = 0; i < `BTO_DEPTH; i++) begin
			if (bto_cnt_t'(i) < cnt) begin
				case (ent[i].cls)
					cls_posted_write: begin
						if (!seen_pw) begin
							pw_ok  = 1'b1;
							pw_idx = bto_idx_t'(i);
						end
						seen_pw = 1'b1;
					end
					cls_delayed_read_completion,
					cls_delayed_write_completion: begin
						if (!seen_pw && !cp_ok) begin
							cp_ok  = 1'b1;
							cp_idx = bto_idx_t'(i);
						end
					end
					cls_delayed_read_request,
					cls_delayed_write_request: begin
						if (!seen_pw && !rq_ok && room_other) begin
							rq_ok  = 1'b1;
							rq_idx = bto_idx_t'(i);
						end
					end
					default: begin
					end
				endcase
			end
		end
		// Completions go ahead of requests; posted writes alternate with both
		if (pw_ok && (!(cp_ok || rq_ok) || !pref_delayed)) begin
			ok  = 1'b1;
			idx = pw_idx;
		end else if (cp_ok) begin
			ok  = 1'b1;
			idx = cp_idx;
		end else if (rq_ok) begin
			ok  = 1'b1;
			idx = rq_idx;
		end
	end

endmodule

// file: bto_top.sv
// Transaction ordering queues of a two-direction bridge with delayed transactions
`timescale 1ns/100ps
`include "bto_defines.svh"

// Overview of operation
// - A read completion carries returned data plus target status back to origin.
// - A write completion carries only status back, no data.
// - Posted writes leave in exactly the order they were accepted.
// - A read request never goes ahead of an earlier posted write.
// - A non-postable write request never goes ahead of an earlier posted write.
// - A read completion waits for earlier posted writes in its return direction.
// - A posted write may overtake a blocking delayed request.
// - A posted write may overtake a blocking delayed completion.
// - A delayed completion may overtake an earlier delayed request.
// - Posted writes get fair turns while delayed requests are being retried.
// - Delayed requests stay in order among themselves here.
// - Requests do not pass eligible completions here; either choice is allowed.
// - Delayed completions stay in order among themselves here.
// - A write completion stays behind earlier posted writes here.
// - Untried requests may be dropped; tried ones are retried until done.
// - Memory write and write-and-invalidate are always posted writes.
// - Delayed flow: latch and retry, complete on far bus, master repeats.
module bto_top
	import bto_pkg::*;
(
	input  logic     mclk,
	input  logic     reset,
	input  logic     acc_valid  [`BTO_DIRS],
	input  bto_txn_s acc_txn    [`BTO_DIRS],
	output logic     acc_ready  [`BTO_DIRS],
	input  logic     drop_req   [`BTO_DIRS],
	output logic     iss_valid  [`BTO_DIRS],
	output bto_ent_s iss_ent    [`BTO_DIRS],
	input  logic     iss_ready  [`BTO_DIRS],
	input  logic     res_valid  [`BTO_DIRS],
	input  bto_res_s res        [`BTO_DIRS],
	output logic     pw_pending [`BTO_DIRS],
	output bto_cnt_t q_level    [`BTO_DIRS]
);

	bto_top_s st_reg;
	bto_top_s st_next;
	logic     pick_ok       [`BTO_DIRS];
	bto_idx_t pick_idx      [`BTO_DIRS];
	logic     pick_fire     [`BTO_DIRS];
	bto_ent_s pick_ent      [`BTO_DIRS];
	logic     skid_in_ready [`BTO_DIRS];
	logic     room_other    [`BTO_DIRS];

	// Class of a newly accepted transaction from its bus command
	function automatic bto_cls_e bto_classify(input bto_cmd_t cmd);
		bto_cls_e c;
		case (cmd)
			`BTO_CMD_MEM_WR,
			`BTO_CMD_MWI:    c = cls_posted_write;
			`BTO_CMD_IO_WR,
			`BTO_CMD_CFG_WR: c = cls_delayed_write_request;
			default:         c = cls_delayed_read_request;
		endcase
		return c;
	endfunction

	// True for both kinds of delayed request
	function automatic logic bto_is_req(input bto_cls_e c);
		return (c == cls_delayed_read_request) || (c == cls_delayed_write_request);
	endfunction

	// Remove one entry and close the gap so index keeps meaning age
	function automatic bto_dq_s bto_q_del(input bto_dq_s q, input bto_idx_t idx);
		bto_dq_s r;
		r = q;
		for (int i = 0; i < `BTO_DEPTH - 1; i++) begin
			if (bto_idx_t'(i) >= idx) begin
				r.ent[i] = q.ent[i + 1];
			end
		end
		r.ent[`BTO_DEPTH-1] = '0;
		r.cnt               = q.cnt - 1'b1;
		if (q.inflight && (idx < q.infl_idx)) begin
			r.infl_idx = q.infl_idx - 1'b1;
		end
		return r;
	endfunction

	// Append at the young end with the next acceptance stamp
	function automatic bto_dq_s bto_q_add(input bto_dq_s q, input bto_ent_s e);
		bto_dq_s  r;
		bto_ent_s n;
		r       = q;
		n       = e;
		n.stamp = q.stamp;
		r.ent[q.cnt[`BTO_IDX_W-1:0]] = n;
		r.cnt   = q.cnt + 1'b1;
		r.stamp = q.stamp + 1'b1;
		return r;
	endfunction

	// Per-direction ordering decision and issue buffer
	for (genvar d = 0; d < `BTO_DIRS; d++) begin : g_dir
		// A request reserves one slot in the return queue for its completion
		assign room_other[d] = (st_reg.q[1-d].cnt < bto_cnt_t'(`BTO_DEPTH - 1));
		assign pick_ent[d]   = st_reg.q[d].ent[pick_idx[d]];
		assign pick_fire[d]  = pick_ok[d] && !st_reg.q[d].inflight &&
		                       skid_in_ready[d] && !drop_req[d];
		assign acc_ready[d]  = st_reg.q[d].acc_ready;
		assign pw_pending[d] = st_reg.q[d].pw_pending;
		assign q_level[d]    = st_reg.q[d].level;

		bto_pick u_pick (
			.ent          (st_reg.q[d].ent),
			.cnt          (st_reg.q[d].cnt),
			.room_other   (room_other[d]),
			.pref_delayed (st_reg.q[d].pref_delayed),
			.ok           (pick_ok[d]),
			.idx          (pick_idx[d])
		);

		bto_skid u_skid (
			.mclk      (mclk),
			.reset     (reset),
			.in_valid  (pick_fire[d]),
			.in_ent    (pick_ent[d]),
			.in_ready  (skid_in_ready[d]),
			.out_valid (iss_valid[d]),
			.out_ent   (iss_ent[d]),
			.out_ready (iss_ready[d])
		);
	end

	// Next state of both queues: results and drops, then appends, then issue
	always_comb begin
		bto_ent_s cpl       [`BTO_DIRS];
		logic     cpl_vld   [`BTO_DIRS];
		bto_ent_s cur;
		bto_ent_s nw;
		logic     drop_hit;
		bto_idx_t drop_idx;
		logic     rsv;
		logic     pw_any;
		int       o;
		cur      = '0;
		nw       = '0;
		drop_hit = 1'b0;
		drop_idx = '0;
		rsv      = 1'b0;
		pw_any   = 1'b0;
		o        = 0;
		for (int d = 0; d < `BTO_DIRS; d++) begin
			cpl[d]     = '0;
			cpl_vld[d] = 1'b0;
		end
		st_next = st_reg;

		// Outcome of the attempt in flight, or a drop of an untried request
		for (int d = 0; d < `BTO_DIRS; d++) begin
			o   = `BTO_DIRS - 1 - d;
			cur = st_reg.q[d].ent[st_reg.q[d].infl_idx];
			if (st_reg.q[d].inflight && res_valid[d]) begin
				st_next.q[d].inflight = 1'b0;
				if (res[d].retry) begin
					st_next.q[d].ent[st_reg.q[d].infl_idx].tried = 1'b1;
				end else begin
					if (bto_is_req(cur.cls)) begin
						// Finished on the far bus: becomes a completion heading back
						cpl_vld[o]  = 1'b1;
						cpl[o]      = cur;
						cpl[o].sts  = res[d].sts;
						cpl[o].tried = 1'b0;
						if (cur.cls == cls_delayed_read_request) begin
							cpl[o].cls  = cls_delayed_read_completion;
							cpl[o].data = res[d].data;
						end else begin
							cpl[o].cls  = cls_delayed_write_completion;
							cpl[o].data = '0;
						end
					end
					st_next.q[d] = bto_q_del(st_next.q[d], st_reg.q[d].infl_idx);
				end
			end else if (drop_req[d]) begin
				drop_hit = 1'b0;
				drop_idx = '0;
				for (int i = 0; i < `BTO_DEPTH; i++) begin
					if ((bto_cnt_t'(i) < st_reg.q[d].cnt) &&
					    bto_is_req(st_reg.q[d].ent[i].cls) &&
					    !st_reg.q[d].ent[i].tried &&
					    !(st_reg.q[d].inflight && (st_reg.q[d].infl_idx == bto_idx_t'(i)))) begin
						drop_hit = 1'b1;
						drop_idx = bto_idx_t'(i);
					end
				end
				if (drop_hit) begin
					st_next.q[d] = bto_q_del(st_next.q[d], drop_idx);
				end
			end
		end

		// Completions enter their return queue ahead of same-cycle acceptances
		for (int d = 0; d < `BTO_DIRS; d++) begin
			if (cpl_vld[d]) begin
				st_next.q[d] = bto_q_add(st_next.q[d], cpl[d]);
			end
			if (acc_valid[d] && st_reg.q[d].acc_ready) begin
				nw       = '0;
				nw.cls   = bto_classify(acc_txn[d].cmd);
				nw.cmd   = acc_txn[d].cmd;
				nw.addr  = acc_txn[d].addr;
				nw.data  = acc_txn[d].data;
				nw.sts   = sts_normal;
				st_next.q[d] = bto_q_add(st_next.q[d], nw);
			end
		end

		// Start an attempt and flip the turn between posted and delayed work
		for (int d = 0; d < `BTO_DIRS; d++) begin
			if (pick_fire[d]) begin
				st_next.q[d].inflight     = 1'b1;
				st_next.q[d].infl_idx     = pick_idx[d];
				st_next.q[d].pref_delayed = (pick_ent[d].cls == cls_posted_write);
			end
		end

		// Acceptance room counts the slot reserved for a pending completion
		for (int d = 0; d < `BTO_DIRS; d++) begin
			o      = `BTO_DIRS - 1 - d;
			rsv    = st_next.q[o].inflight &&
			         bto_is_req(st_next.q[o].ent[st_next.q[o].infl_idx].cls);
			pw_any = 1'b0;
			for (int i = 0; i < `BTO_DEPTH; i++) begin
				if ((bto_cnt_t'(i) < st_next.q[d].cnt) &&
				    (st_next.q[d].ent[i].cls == cls_posted_write)) begin
					pw_any = 1'b1;
				end
			end
			st_next.q[d].acc_ready  = ((st_next.q[d].cnt + bto_cnt_t'(rsv)) <
			                           bto_cnt_t'(`BTO_DEPTH));
			st_next.q[d].pw_pending = pw_any;
			st_next.q[d].level      = st_next.q[d].cnt;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule

// file: bto_top_monitor.sv
// Assertion checker for the transaction ordering queues
`timescale 1ns/100ps
`include "bto_defines.svh"
module bto_top_monitor
	import bto_pkg::*;
(
	input logic     mclk,
	input logic     reset,
	input logic     acc_valid  [`BTO_DIRS],
	input logic     acc_ready  [`BTO_DIRS],
	input logic     iss_valid  [`BTO_DIRS],
	input bto_ent_s iss_ent    [`BTO_DIRS],
	input logic     iss_ready  [`BTO_DIRS],
	input logic     pw_pending [`BTO_DIRS],
	input bto_cnt_t q_level    [`BTO_DIRS]
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Per-direction checks on queue level, issue handshake and entry contents
	for (genvar d = 0; d < `BTO_DIRS; d++) begin : g_dir
		property p_rst; @(posedge mclk) disable iff (1'b0)
			reset |=> !acc_ready[d] && !iss_valid[d] && q_level[d] == 3'h0; endproperty
		a_rst: assert property (p_rst) else $error("outputs not cleared");
		property p_cap; q_level[d] <= 3'h4; endproperty
		a_cap: assert property (p_cap) else $error("level over depth");
		property p_fill; acc_valid[d] && acc_ready[d] |=> q_level[d] != 3'h0; endproperty
		a_fill: assert property (p_fill) else $error("taken entry lost");
		property p_pwq; pw_pending[d] |-> q_level[d] != 3'h0; endproperty
		a_pwq: assert property (p_pwq) else $error("posted flag on empty queue");
		property p_hold; iss_valid[d] && !iss_ready[d] |=> iss_valid[d] && $stable(iss_ent[d]);
		endproperty
		a_hold: assert property (p_hold) else $error("issue changed while stalled");
		property p_one; iss_valid[d] && iss_ready[d] |=> !iss_valid[d]; endproperty
		a_one: assert property (p_one) else $error("second attempt in flight");
		property p_pcmd; iss_valid[d] |-> (iss_ent[d].cls == cls_posted_write) ==
			(iss_ent[d].cmd inside {`BTO_CMD_MEM_WR, `BTO_CMD_MWI}); endproperty
		a_pcmd: assert property (p_pcmd) else $error("posted class mismatch");
		property p_wdat; iss_valid[d] && iss_ent[d].cls == cls_delayed_write_completion
			|-> iss_ent[d].data == 32'h0; endproperty
		a_wdat: assert property (p_wdat) else $error("write completion has data");
	end
	c_retry: cover property (iss_valid[0] && iss_ready[0] && iss_ent[0].tried);
	c_full: cover property (q_level[0] == 3'h4 && !acc_ready[0]);
	c_wcpl: cover property (iss_valid[1] && iss_ent[1].cls == cls_delayed_write_completion);
endmodule

bind bto_top bto_top_monitor u_mon (.mclk(mclk), .reset(reset), .acc_valid(acc_valid),
	.acc_ready(acc_ready), .iss_valid(iss_valid), .iss_ent(iss_ent), .iss_ready(iss_ready),
	.pw_pending(pw_pending), .q_level(q_level));

// file: bto_far.sv
// Far-bus model that takes issued entries and answers each with one result
`timescale 1ns/100ps
module bto_far
	import bto_pkg::*;
(
	input  logic     mclk,
	input  logic     reset,
	input  logic     stall,
	input  logic     retry_on,
	input  bto_sts_e sts_sel,
	input  logic     iss_valid,
	input  bto_ent_s iss_ent,
	output logic     iss_ready,
	output logic     res_valid,
	output bto_res_s res
);
	bto_ent_s   log [$];
	bto_ent_s   held;
	logic       busy = 1'b0;
	logic [1:0] wait_cnt = 2'h0;
	bto_word_t  junk = 32'h0;
	// Ready only while idle and not told to stall
	assign iss_ready = !stall && !busy;
	// Answer three cycles after taking; idle result lines keep changing
	always @(posedge mclk) begin
		res_valid <= 1'b0;
		res <= '{1'b1, bto_sts_e'(junk[1:0]), junk};
		junk <= junk + 32'h9E37_79B9;
		if (reset) begin
			busy <= 1'b0;
		end else if (iss_valid && iss_ready) begin
			log.push_back(iss_ent);
			held <= iss_ent;
			busy <= 1'b1;
			wait_cnt <= 2'h2;
		end else if (busy && wait_cnt != 2'h0) begin
			wait_cnt <= wait_cnt - 2'h1;
		end else if (busy) begin
			res_valid <= 1'b1;
			res <= '{retry_on, sts_sel, ~held.addr};
			busy <= 1'b0;
		end
	end
endmodule

// file: tb.sv
// Self-checking bench for the transaction ordering queues
`timescale 1ns/100ps
`include "bto_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb;
	import bto_pkg::*;
	logic          mclk = 1'b0;
	logic          reset = 1'b1;
	logic          acc_valid [2] = '{default: 1'b0};
	bto_txn_s      acc_txn [2] = '{default: '0};
	logic          drop_req [2] = '{default: 1'b0};
	logic          stall [2] = '{default: 1'b0};
	logic          retry_on = 1'b0;
	bto_sts_e      sts_sel = sts_normal;
	int            failures = 0;
	int            tests_run = 0;
	int            cyc = 0;
	wire           acc_ready [2];
	wire           iss_valid [2];
	wire           iss_ready [2];
	wire           res_valid [2];
	wire           pw_pending [2];
	wire bto_ent_s iss_ent [2];
	wire bto_res_s res [2];
	wire bto_cnt_t q_level [2];
	bto_top DUT (.mclk(mclk), .reset(reset), .acc_valid(acc_valid), .acc_txn(acc_txn),
		.acc_ready(acc_ready), .drop_req(drop_req), .iss_valid(iss_valid), .iss_ent(iss_ent),
		.iss_ready(iss_ready), .res_valid(res_valid), .res(res), .pw_pending(pw_pending),
		.q_level(q_level));
	// One far-bus model per direction
	for (genvar d = 0; d < 2; d++) begin : f
		bto_far m (.mclk(mclk), .reset(reset), .stall(stall[d]), .retry_on(retry_on && d == 0),
			.sts_sel(sts_sel), .iss_valid(iss_valid[d]), .iss_ent(iss_ent[d]),
			.iss_ready(iss_ready[d]), .res_valid(res_valid[d]), .res(res[d]));
	end
	always #4 mclk = ~mclk;
	// Cut a hung run short
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			conclude();
		end
	end
	task automatic conclude();
		if (failures == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask
	// Offer one transaction and hold it until the edge that takes it
	task automatic put(int d, bto_cmd_t c, bto_addr_t a);
		int   n;
		logic ok;
		n = 0;
		acc_valid[d] = 1'b1;
		acc_txn[d] = '{c, a, ~a};
		do begin
			ok = acc_ready[d];
			tick();
			n++;
		end while (ok !== 1'b1 && n < 50);
		`CHK("accept", 1'b1, ok)
	endtask
	task automatic drain();
		int n;
		n = 0;
		while ((q_level[0] | q_level[1]) !== 3'h0 && n < 200) begin
			tick();
			n++;
		end
	endtask
	// Every command kind, its class and the completion it returns
	task automatic t_classes();
		bto_cmd_t  cmds [6] = '{4'h7, 4'hF, 4'h3, 4'hB, 4'h6, 4'h0};
		bto_cls_e  ex;
		bto_addr_t a;
		for (int i = 0; i < 6; i++) begin
			f[0].m.log.delete();
			f[1].m.log.delete();
			a = 32'h100 + i;
			ex = (cmds[i] inside {4'h7, 4'hF}) ? cls_posted_write :
				(cmds[i] inside {4'h3, 4'hB}) ? cls_delayed_write_request :
				cls_delayed_read_request;
			put(0, cmds[i], a);
			acc_valid[0] = 1'b0;
			sts_sel = bto_sts_e'(i % 4);
			drain();
			`CHK("class", ex, f[0].m.log[0].cls)
			if (ex != cls_posted_write) begin
				`CHK("cpl class", ex + 3'h2, f[1].m.log[0].cls)
				`CHK("cpl status", sts_sel, f[1].m.log[0].sts)
				a = (ex == cls_delayed_read_request) ? ~a : 32'h0;
				`CHK("cpl data", a, f[1].m.log[0].data)
			end
		end
	endtask
	// A posted write overtakes a retried read, which is then retried
	task automatic t_pass();
		int n;
		n = 0;
		f[0].m.log.delete();
		put(0, 4'h6, 32'h400);
		put(0, 4'h7, 32'h410);
		acc_valid[0] = 1'b0;
		retry_on = 1'b1;
		while (f[0].m.log.size() < 3 && n < 100) begin
			tick();
			n++;
		end
		retry_on = 1'b0;
		drain();
		`CHK("first try", 1'b0, f[0].m.log[0].tried)
		`CHK("pw passes", cls_posted_write, f[0].m.log[1].cls)
		`CHK("retried", 1'b1, f[0].m.log[2].tried)
	endtask
	// Fill one queue against a stalled far side, then drain in order
	task automatic t_full();
		int k;
		k = 0;
		f[0].m.log.delete();
		stall[0] = 1'b1;
		acc_valid[0] = 1'b1;
		repeat (8) begin
			acc_txn[0] = '{4'h7, bto_addr_t'(k), 32'h0};
			if (acc_ready[0] === 1'b1) k++;
			tick();
		end
		acc_valid[0] = 1'b0;
		`CHK("taken", 4, k)
		`CHK("full level", 3'h4, q_level[0])
		`CHK("pw flag set", 1'b1, pw_pending[0])
		stall[0] = 1'b0;
		drain();
		`CHK("pw flag clear", 1'b0, pw_pending[0])
		for (int i = 0; i < 4; i++) begin
			`CHK("pw order", i, f[0].m.log[i].addr)
			`CHK("stamp order", f[0].m.log[0].stamp + 8'(i), f[0].m.log[i].stamp)
		end
	endtask
	// Drop the youngest untried request while a posted write is stuck
	task automatic t_drop();
		f[0].m.log.delete();
		put(0, 4'h7, 32'h200);
		stall[0] = 1'b1;
		put(0, 4'h6, 32'h210);
		put(0, 4'h3, 32'h220);
		acc_valid[0] = 1'b0;
		tick();
		drop_req[0] = 1'b1;
		tick();
		drop_req[0] = 1'b0;
		`CHK("dropped", 3'h2, q_level[0])
		stall[0] = 1'b0;
		drain();
		`CHK("pw ahead", cls_posted_write, f[0].m.log[0].cls)
		`CHK("kept read", 32'h210, f[0].m.log[1].addr)
		`CHK("issued", 2, f[0].m.log.size())
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk);
		#1 reset = 1'b0;
		`CHK("ready held low", 1'b0, acc_ready[0])
		tick();
		`CHK("ready after reset", 1'b1, acc_ready[0])
		t_classes();
		t_pass();
		t_full();
		t_drop();
		conclude();
	end
endmodule
